// file: sipm_map.vh
`ifndef SIPM_MAP_VH
`define SIPM_MAP_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define SIPM_OFF_WAKEMSK   12'h034
`define SIPM_OFF_PWRCTRL   12'h03C
`define SIPM_OFF_WAKESRC   12'h05C
`define SIPM_OFF_SLPPWR    12'h078
`define SIPM_OFF_SLEEP     12'h07C
`define SIPM_OFF_IDLECTL   12'h080
`define SIPM_OFF_STATUS    12'h084
`define SIPM_OFF_INPUTEN   12'h088
// ---------------------------------------------------------------
// fields
// ---------------------------------------------------------------
`define SIPM_MSK_W         9
`define SIPM_MSK_CAL       8
`define SIPM_POWER_UP_DELAY_FIELD_W        5
`define SIPM_SRC_SLEEP     9
`define SIPM_IDLE_SNOOP    0
`define SIPM_IDLE_NOSNOOP  1
`define SIPM_IDLE_SEL      0
`define SIPM_ZERO32        32'h00000000
// ---------------------------------------------------------------
// timing (cpu clocks), power-up delay field shift and boot address
// ---------------------------------------------------------------
`define SIPM_CLK_RESTART   4'h7
`define SIPM_CORE_RECOG    4'hA
`define SIPM_POWER_UP_DELAY_FIELD_SHIFT    8
`define SIPM_BOOT_ADDR     32'h1FC00000
`endif

// file: sipm_sync.v
`timescale 1ns/1ps
`default_nettype none
module sipm_sync
#(
  parameter W = 1
)
(
  // clock and reset
  input  wire         clk,
  input  wire         resetn,
  // data
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // sipm_sync
`default_nettype wire

// file: sipm_power_manager.v
// Functional notes
// - any interrupt ends idle; only enabled gpio or calendar match ends sleep
// - snooping idle keeps bus snoop enabled
// - non-snooping idle stops bus snoop; coherency lost
// - idle entered only when wait and four following instructions cached
// - cpu clocks restart five to ten clocks after idle wake interrupt
// - ten more clocks to handler; total at most twenty clocks
// - mmu, dcache, exec, mac units held low power when unused
// - sleep loses registers outside system control; full reinit after wake
// - calendar counter runs in sleep; second counter and clocks stopped
// - write to sleep-trigger register puts device to sleep only once the sleep-power register has been armed
// - entering sleep deasserts power-enable output
// - power-enable asserts once supply-good is active at power-on
// - sleep wake asserts power-enable then waits power-up delay
// - power-up wait lasts as the delay field specifies
// - after wake delay processor boots from normal boot address
// - wake-cause reports sleep return and source; software write clears
// - set wake-mask bit lets its event wake the device
// - enabled gpio wakes on high level
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sipm_map.vh"
module sipm_power_manager
(
  // clock and reset
  input  wire        clk,
  input  wire        resetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // pins and events
  input  wire        io_supply_good_in,
  input  wire [7:0]  gpio_in,
  input  wire        calendar_match_two,
  input  wire        cpu_irq,
  // cpu core handshake
  input  wire        wait_exec,
  input  wire        wait_lines_cached,
  input  wire        unit_busy_mmu,
  input  wire        unit_busy_dcache,
  input  wire        unit_busy_exec,
  input  wire        unit_busy_mac,
  // outputs
  output reg         sleep_power_enable_out,
  output reg         cpu_clk_en,
  output reg         bus_snoop_en,
  output reg         cpu_run,
  output reg         boot_req,
  output reg  [31:0] boot_addr,
  output reg         domain_reset,
  output reg         counter1_clk_en,
  output reg         calendar_clk_en,
  output reg  [3:0]  unit_lowpower,
  output reg         coherency_lost
);
  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam [2:0] ST_OFF     = 3'h0;
  localparam [2:0] ST_RUN     = 3'h1;
  localparam [2:0] ST_IDLE    = 3'h2;
  localparam [2:0] ST_IWAKE   = 3'h3;
  localparam [2:0] ST_IRECOG  = 3'h4;
  localparam [2:0] ST_SLEEP   = 3'h5;
  localparam [2:0] ST_PWRUP   = 3'h6;

  reg  [2:0]               state;
  reg  [2:0]               next_state;
  reg  [15:0]              cnt;
  reg  [`SIPM_MSK_W-1:0]   wake_mask;
  reg  [`SIPM_POWER_UP_DELAY_FIELD_W-1:0]  power_up_delay_field;
  reg  [`SIPM_SRC_SLEEP:0] wake_cause;
  reg                      idle_nosnoop;
  reg                      slp_armed;
  reg                      inputs_en;
  wire [7:0]               gpio_s;
  wire [1:0]               misc_s;
  wire                     supply_ok;
  wire                     cal_s;
  wire [`SIPM_MSK_W-1:0]   wake_hits;
  wire                     acc;
  wire                     wr;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  sipm_sync #(.W(8)) u_gsync
  (
    .clk    (clk),
    .resetn (resetn),
    .d      (gpio_in),
    .q      (gpio_s)
  );
  sipm_sync #(.W(2)) u_msync
  (
    .clk    (clk),
    .resetn (resetn),
    .d      ({io_supply_good_in, calendar_match_two}),
    .q      (misc_s)
  );
  assign supply_ok = misc_s[1];
  assign cal_s     = misc_s[0];

  // high level, masked, gpio only once inputs are enabled
  assign wake_hits = {cal_s, gpio_s & {8{inputs_en}}} & wake_mask;

  function is_reg;
    input [11:0] a;
    input [11:0] off;
    begin
      is_reg = (a == off);
    end
  endfunction

  function [15:0] pwrup_cycles;
    input [`SIPM_POWER_UP_DELAY_FIELD_W-1:0] f;
    begin
      pwrup_cycles = {3'h0, f, 8'h00} + 16'h0001;
    end
  endfunction

  // ---------------------------------------------------------------
  // apb: one wait state, unmapped reads zero with pslverr
  // ---------------------------------------------------------------
  assign acc = psel && penable && !pready;
  // a write commits on the completing edge, when the master sees pready
  assign wr  = psel && penable && pready && pwrite;

  always @(posedge clk)
  begin
    if (!resetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `SIPM_ZERO32;
    end
    else
    begin
      pready  <= acc;
      pslverr <= 1'b0;
      prdata  <= `SIPM_ZERO32;
      if (acc)
      begin
        case (paddr)
          `SIPM_OFF_WAKEMSK: prdata <= {23'h0, wake_mask};
          `SIPM_OFF_PWRCTRL: prdata <= {19'h0, power_up_delay_field, 8'h00};
          `SIPM_OFF_WAKESRC: prdata <= {22'h0, wake_cause};
          `SIPM_OFF_SLPPWR:  prdata <= {31'h0, slp_armed};
          `SIPM_OFF_SLEEP:   prdata <= `SIPM_ZERO32;
          `SIPM_OFF_IDLECTL: prdata <= {31'h0, idle_nosnoop};
          `SIPM_OFF_STATUS:  prdata <= {27'h0, inputs_en, sleep_power_enable_out, state};
          `SIPM_OFF_INPUTEN: prdata <= `SIPM_ZERO32;
          default:           pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // registers kept in the system control domain
  // ---------------------------------------------------------------
  // these survive sleep except slp_armed, which sleep clears; a write also clears wake_cause
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      wake_mask            <= {`SIPM_MSK_W{1'b0}};
      power_up_delay_field <= {`SIPM_POWER_UP_DELAY_FIELD_W{1'b0}};
      idle_nosnoop         <= 1'b0;
      slp_armed            <= 1'b0;
      inputs_en            <= 1'b0;
      wake_cause           <= {(`SIPM_SRC_SLEEP+1){1'b0}};
    end
    else
    begin
      if (wr && is_reg(paddr, `SIPM_OFF_WAKEMSK))
        wake_mask <= pwdata[`SIPM_MSK_W-1:0];
      if (wr && is_reg(paddr, `SIPM_OFF_PWRCTRL))
        power_up_delay_field <= pwdata[`SIPM_POWER_UP_DELAY_FIELD_SHIFT+`SIPM_POWER_UP_DELAY_FIELD_W-1:`SIPM_POWER_UP_DELAY_FIELD_SHIFT];
      if (wr && is_reg(paddr, `SIPM_OFF_IDLECTL))
        idle_nosnoop <= pwdata[`SIPM_IDLE_SEL];
      // a fresh arm written during sleep beats that cycle's clear; any later sleep cycle clears it again
      if (state == ST_SLEEP)
        slp_armed <= 1'b0;
      if (wr && is_reg(paddr, `SIPM_OFF_SLPPWR))
        slp_armed <= 1'b1;
      if (wr && is_reg(paddr, `SIPM_OFF_INPUTEN))
        inputs_en <= 1'b1;
      // software clear first; a wake in the same cycle wins unless a wake is already latched
      if (wr && is_reg(paddr, `SIPM_OFF_WAKESRC))
        wake_cause <= {(`SIPM_SRC_SLEEP+1){1'b0}};
      if (state == ST_SLEEP && (|wake_hits) && !wake_cause[`SIPM_SRC_SLEEP])
        wake_cause <= {1'b1, wake_hits};
    end
  end

  // ---------------------------------------------------------------
  // power state machine
  // ---------------------------------------------------------------
  always @*
  begin
    next_state = state;
    case (state)
      ST_OFF:
        if (supply_ok)
          next_state = ST_RUN;
      ST_RUN:
        if (wr && is_reg(paddr, `SIPM_OFF_SLEEP) && slp_armed)
          next_state = ST_SLEEP;
        else if (wait_exec && wait_lines_cached)
          next_state = ST_IDLE;
      ST_IDLE:
        if (cpu_irq)
          next_state = ST_IWAKE;
      ST_IWAKE:
        if (cnt == {12'h0, `SIPM_CLK_RESTART})
          next_state = ST_IRECOG;
      ST_IRECOG:
        if (cnt == {12'h0, `SIPM_CORE_RECOG})
          next_state = ST_RUN;
      ST_SLEEP:
        if (|wake_hits)
          next_state = ST_PWRUP;
      ST_PWRUP:
        if (cnt == pwrup_cycles(power_up_delay_field))
          next_state = ST_RUN;
      default:
        next_state = ST_OFF;
    endcase
  end

  always @(posedge clk)
  begin
    if (!resetn)
    begin
      state <= ST_OFF;
      cnt   <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      if (next_state != state)
        cnt <= 16'h0001;
      else
        cnt <= cnt + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all registered; decoded from next_state, with boot_req and coherency_lost also from state
  // ---------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      sleep_power_enable_out <= 1'b0;
      cpu_clk_en             <= 1'b0;
      bus_snoop_en           <= 1'b0;
      cpu_run                <= 1'b0;
      boot_req               <= 1'b0;
      boot_addr              <= `SIPM_BOOT_ADDR;
      domain_reset           <= 1'b1;
      counter1_clk_en        <= 1'b0;
      calendar_clk_en        <= 1'b0;
      unit_lowpower          <= 4'hF;
      coherency_lost         <= 1'b0;
    end
    else
    begin
      // power stays off in sleep, rises on wake before the delay
      sleep_power_enable_out <= (next_state != ST_OFF) && (next_state != ST_SLEEP);
      cpu_clk_en      <= (next_state == ST_RUN) || (next_state == ST_IRECOG);
      // snoop stays on through snooping idle and its clock restart
      bus_snoop_en    <= (next_state == ST_RUN) || (next_state == ST_IRECOG)
                         || (((next_state == ST_IDLE) || (next_state == ST_IWAKE))
                         && !idle_nosnoop);
      cpu_run         <= (next_state == ST_RUN);
      boot_req        <= (state == ST_PWRUP) && (next_state == ST_RUN);
      boot_addr       <= `SIPM_BOOT_ADDR;
      // registers outside control domain reset across sleep and power-up
      domain_reset    <= (next_state == ST_OFF) || (next_state == ST_SLEEP)
                         || (next_state == ST_PWRUP);
      counter1_clk_en <= (next_state == ST_RUN) || (next_state == ST_IDLE)
                         || (next_state == ST_IWAKE) || (next_state == ST_IRECOG);
      calendar_clk_en <= (next_state != ST_OFF);
      unit_lowpower   <= ~({unit_busy_mac, unit_busy_exec, unit_busy_dcache, unit_busy_mmu}
                         & {4{next_state == ST_RUN}});
      if (next_state == ST_IDLE && idle_nosnoop)
        coherency_lost <= 1'b1;
      else if (next_state == ST_SLEEP)
        coherency_lost <= 1'b1;
      else if (next_state == ST_RUN && state == ST_RUN)
        coherency_lost <= 1'b0;
    end
  end
endmodule // sipm_power_manager
`default_nettype wire

// file: sipm_power_manager_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sipm_mon (
  // apb
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // core and power
  input wire logic        cpu_irq,
  input wire logic        wait_lines_cached,
  input wire logic        cpu_clk_en,
  input wire logic        cpu_run,
  input wire logic        bus_snoop_en,
  input wire logic        coherency_lost,
  input wire logic        domain_reset,
  input wire logic        sleep_power_enable_out,
  input wire logic        counter1_clk_en,
  input wire logic        boot_req,
  input wire logic [31:0] boot_addr
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence idle_irq;
    $rose(cpu_irq) && !cpu_clk_en && !domain_reset;
  endsequence
  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("no apb answer");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  clk_restart_a: assert property (idle_irq |-> !cpu_clk_en [*5] ##[1:6] cpu_clk_en)
    else $error("idle clock restart out of range");
  idle_total_a: assert property (idle_irq |-> ##[1:20] cpu_run)
    else $error("idle resume too late");
  idle_guard_a: assert property (cpu_clk_en && !wait_lines_cached && !domain_reset
    |=> cpu_clk_en || domain_reset)
    else $error("idle without cached lines");
  snoop_off_a: assert property (!domain_reset && !bus_snoop_en |-> coherency_lost)
    else $error("snoop off without coherency flag");
  sleep_pwr_a: assert property ($fell(sleep_power_enable_out) |-> ##[0:1] domain_reset)
    else $error("power off outside sleep");
  sleep_clk_a: assert property (!sleep_power_enable_out |-> !counter1_clk_en && !cpu_clk_en)
    else $error("clock running while powered off");
  boot_addr_a: assert property (boot_req |-> boot_addr == 32'h1FC00000 && sleep_power_enable_out)
    else $error("bad boot");
  cover property ($rose(boot_req));
  cover property ($fell(sleep_power_enable_out));
  cover property (!cpu_clk_en && !domain_reset && !bus_snoop_en);
endmodule // sipm_mon
bind sipm_power_manager sipm_mon mon (.clk, .resetn, .psel, .penable, .pready, .pslverr,
  .cpu_irq, .wait_lines_cached, .cpu_clk_en, .cpu_run, .bus_snoop_en, .coherency_lost,
  .domain_reset, .sleep_power_enable_out, .counter1_clk_en, .boot_req, .boot_addr);
`default_nettype wire

// file: sipm_board.sv
`timescale 1ns/1ps
`default_nettype none
module sipm_board (
  // supplies
  input  wire logic clk,
  input  wire logic sleep_power_enable_out,
  output var  logic io_supply_good_in,
  output var  logic core_ok
);
  // ----------------------------------------
  // regulators
  // ----------------------------------------
  logic ramp = 1'b1;
  int   t    = 0;
  // secondary rail also on during the first ramp, before the device can drive it
  wire  sec_en = sleep_power_enable_out | ramp;
  always @(posedge clk)
  begin
    t <= sec_en ? t + 1 : 0;
    if (t == 8)
      ramp <= 1'b0;
  end
  // good stays high through sleep, only the switched rails drop
  assign io_supply_good_in = !ramp;
  assign core_ok = t > 100;
endmodule // sipm_board
`default_nettype wire

// file: sipm_power_manager_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sipm_map.vh"
module sipm_power_manager_tb;
  logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, boot_addr, rd;
  logic [7:0]  gpio_in = 8'h00;
  logic [3:0]  unit_lowpower;
  logic        calendar_match_two = 1'b0, cpu_irq = 1'b0, wait_exec = 1'b0;
  logic        wait_lines_cached = 1'b0, unit_busy_mmu = 1'b0, unit_busy_dcache = 1'b0;
  logic        unit_busy_exec = 1'b0, unit_busy_mac = 1'b0, pready, pslverr, rerr, core_ok;
  logic        io_supply_good_in, sleep_power_enable_out, cpu_clk_en, bus_snoop_en, cpu_run;
  logic        boot_req, domain_reset, counter1_clk_en, calendar_clk_en, coherency_lost;
  int          err_total = 0, comparisons = 0, n, k;
  // ----------------------------------------
  // harness
  // ----------------------------------------
  sipm_power_manager DUT (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .io_supply_good_in, .gpio_in, .calendar_match_two, .cpu_irq,
    .wait_exec, .wait_lines_cached, .unit_busy_mmu, .unit_busy_dcache, .unit_busy_exec,
    .unit_busy_mac, .sleep_power_enable_out, .cpu_clk_en, .bus_snoop_en, .cpu_run, .boot_req,
    .boot_addr, .domain_reset, .counter1_clk_en, .calendar_clk_en, .unit_lowpower,
    .coherency_lost);
  sipm_board board (.clk, .sleep_power_enable_out, .io_supply_good_in, .core_ok);
  always #25 clk = ~clk;
  task automatic end_of_test(input bit to);
    if (to)
      err_total++;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one extra edge first so a released strobe never rises again in the same step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int c;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    c = 0;
    do
    begin
      @(posedge clk);
      c++;
    end
    while (pready !== 1'b1 && c < 50);
    if (c >= 50)
      end_of_test(1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return sleep_power_enable_out;
      1: return cpu_clk_en;
      2: return cpu_run;
      default: return boot_req;
    endcase
  endfunction
  task automatic waitc(input int s, input logic v, input int lim, output int c);
    c = 0;
    do
    begin
      @(posedge clk);
      c++;
    end
    while (pick(s) !== v && c < lim);
    if (c >= lim)
      end_of_test(1);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    waitc(0, 1'b1, 40, n);
    chk("supply_good", 1'b1, io_supply_good_in);
    apb(0, 12'h100, 32'h00000000);
    chk("unmapped_err", 1'b1, rerr);
    apb(1, `SIPM_OFF_WAKEMSK, 32'hFFFFFFFF);
    apb(0, `SIPM_OFF_WAKEMSK, 32'h00000000);
    chk("wakemsk", 32'h000001FF, rd);
    unit_busy_mmu <= 1'b1;
    repeat (3) @(posedge clk);
    chk("lowpower", 4'hE, unit_lowpower);
    unit_busy_mmu <= 1'b0;
    for (int m = 0; m < 2; m++)
    begin
      apb(1, `SIPM_OFF_IDLECTL, m);
      wait_exec <= 1'b1;
      repeat (4) @(posedge clk);
      chk("clk_uncached", 1'b1, cpu_clk_en);
      wait_lines_cached <= 1'b1;
      waitc(1, 1'b0, 20, n);
      chk("snoop", !m, bus_snoop_en);
      chk("coh_lost", m, coherency_lost);
      // the wait has retired once the core idles, so wake cannot re-enter idle
      wait_exec <= 1'b0;
      wait_lines_cached <= 1'b0;
      cpu_irq <= 1'b1;
      waitc(1, 1'b1, 30, n);
      chk("restart", 1'b1, n >= 5 && n <= 10);
      waitc(2, 1'b1, 30, k);
      chk("resume", 1'b1, n + k <= 20);
      cpu_irq <= 1'b0;
    end
    apb(1, `SIPM_OFF_PWRCTRL, 32'h00000100);
    apb(1, `SIPM_OFF_INPUTEN, 32'h00000000);
    for (int s = 0; s < 2; s++)
    begin
      apb(1, `SIPM_OFF_SLEEP, 32'h00000000);
      repeat (5) @(posedge clk);
      chk("unarmed", 1'b1, sleep_power_enable_out);
      apb(1, `SIPM_OFF_WAKEMSK, s ? 32'h00000100 : 32'h00000004);
      apb(1, `SIPM_OFF_WAKESRC, 32'h00000000);
      apb(1, `SIPM_OFF_SLPPWR, 32'h00000000);
      apb(1, `SIPM_OFF_SLEEP, 32'h00000000);
      waitc(0, 1'b0, 20, n);
      chk("dom_rst", 1'b1, domain_reset);
      chk("cal_clk", 1'b1, calendar_clk_en);
      chk("cnt1_clk", 1'b0, counter1_clk_en);
      gpio_in <= 8'h02;
      cpu_irq <= 1'b1;
      repeat (10) @(posedge clk);
      chk("masked", 1'b0, sleep_power_enable_out);
      if (s)
        calendar_match_two <= 1'b1;
      else
        gpio_in <= 8'h06;
      waitc(0, 1'b1, 20, n);
      waitc(3, 1'b1, 400, n);
      chk("pwrup_wait", 32'd257, n);
      chk("boot_addr", `SIPM_BOOT_ADDR, boot_addr);
      chk("core_ok", 1'b1, core_ok);
      gpio_in <= 8'h00;
      calendar_match_two <= 1'b0;
      cpu_irq <= 1'b0;
      apb(0, `SIPM_OFF_WAKESRC, 32'h00000000);
      chk("cause", s ? 32'h00000300 : 32'h00000204, rd);
      apb(1, `SIPM_OFF_WAKESRC, 32'h00000000);
      apb(0, `SIPM_OFF_WAKESRC, 32'h00000000);
      chk("cause_clear", 32'h00000000, rd);
    end
    end_of_test(0);
  end
endmodule // sipm_power_manager_tb
`default_nettype wire
